// ===== hdl/profile_latency_defines.vh
`ifndef PROFILE_LATENCY_DEFINES_VH
`define PROFILE_LATENCY_DEFINES_VH
// byte address is four times the register index
`define IDX_P2_FREQ0   8'h0E
`define IDX_P2_FREQ1   8'h0F
`define IDX_P2_FREQ2   8'h10
`define IDX_P2_FREQ3   8'h11
`define IDX_P2_RATE    8'h12
`define IDX_P2_GAIN    8'h13
`define IDX_P3_FREQ0   8'h14
`define IDX_P3_FREQ1   8'h15
`define IDX_P3_FREQ2   8'h16
`define IDX_P3_FREQ3   8'h17
`define IDX_P3_RATE    8'h18
`define IDX_P3_GAIN    8'h19
`define IDX_CONFIG     8'h20
`define IDX_STATUS     8'h21
`define IDX_LATENCY    8'h22
`define IDX_APPLY      8'h23
// rate byte fields
`define RATE_LSB       0
`define RATE_MSB       5
`define RATE_INV_BIT   6
`define RATE_ICIC_BIT  7
`define RATE_BYPASS    6'h01
// config fields: mode[1:0], inv sinc on [2], scaler on [3], mult [8:4]
`define CFG_MODE_LSB   0
`define CFG_MODE_MSB   1
`define CFG_ISINC_BIT  2
`define CFG_SCALE_BIT  3
`define CFG_MULT_LSB   4
`define CFG_MULT_MSB   8
`define CFG_RESET      32'h00000010
`define MODE_QMOD      2'h0
`define MODE_TONE      2'h1
`define MODE_INTERP    2'h2
`define MULT_BYPASS    5'h01
`define MULT_MIN       5'h04
`define MULT_MAX       5'h14
// latency coefficients in core clock cycles
`define LAT_DEMUX_MOD  12'h004
`define LAT_DEMUX_INT  12'h008
`define LAT_ICIC       12'h00C
`define LAT_FIXED      12'h048
`define LAT_PROG_K     12'h005
`define LAT_PROG_C     12'h009
`define LAT_QMOD       12'h007
`define LAT_ISINC      12'h007
`define LAT_SCALE      12'h006
`define TONE_SW_FULL   5'h1D
`define TONE_SW_NOSINC 5'h17
`define TONE_SW_BASE   5'h10
`define TONE_SW_SHORT  5'h0A
`define DEMUX_STAGES   2'h3
`define HTRANS_NONSEQ  1'b1
`endif

// ===== hdl/profile_datapath_latency.v
`include "profile_latency_defines.vh"
`default_nettype none
module profile_datapath_latency
(
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  input  wire        profile_sel_lo,
  input  wire        profile_sel_hi,
  input  wire        burst_start,
  input  wire [13:0] sample_in,
  output reg         parallel_data_clock,
  output reg         sample_clock,
  output reg  [13:0] demux_out,
  output reg         demux_valid,
  output reg  [31:0] active_freq_word,
  output reg  [7:0]  active_gain,
  output reg         active_spec_invert,
  output reg         active_icic_bypass,
  output reg  [11:0] latency_cycles
);
  // core clock is hclk here; profiles 0/1 live elsewhere, so they select zero
  reg  [7:0]  p_freq_ff [0:7];
  reg  [7:0]  p_rate_ff [0:1];
  reg  [7:0]  p_gain_ff [0:1];
  reg  [31:0] cfg_ff;
  reg         wr_pend_ff;
  reg  [7:0]  wr_idx_ff;
  reg  [31:0] shadow_ff [0:1];
  reg         sel_lo_meta_ff;
  reg         sel_lo_sync_ff;
  reg         sel_hi_meta_ff;
  reg         sel_hi_sync_ff;
  reg         burst_meta_ff;
  reg         burst_sync_ff;
  reg  [1:0]  profile_ff;
  reg  [5:0]  div_cnt_ff;
  reg         clk_n_ff;
  reg  [13:0] pipe_ff [0:2];
  reg  [2:0]  pipe_vld_ff;
  reg         data_clk_rise;
  reg  [4:0]  hop_cnt_ff;
  reg  [1:0]  hop_prof_ff;
  reg         tone_busy_ff;
  reg  [13:0] hold_ff;
  reg         hold_vld_ff;
  reg         lock_ff;
  reg         from_hold_ff;
  wire [7:0]  bus_idx;
  wire        bus_take;
  wire [7:0]  act_rate;
  wire [5:0]  rate_code;
  wire [5:0]  n_val;
  wire [1:0]  mode;
  wire [4:0]  mult;
  wire [1:0]  pin_profile;
  wire        apply_wr;
  wire        hi_prof;
  wire [4:0]  hop_limit;
  wire        use_hold;
  reg  [31:0] rd_mux;
  reg  [11:0] lat_sum;
  wire [5:0]  div_half;
  integer     i;

  assign bus_idx  = haddr[9:2];
  assign bus_take = hsel & hready & htrans[1] & (htrans[0] == 1'b0);
  assign mode     = cfg_ff[`CFG_MODE_MSB:`CFG_MODE_LSB];
  assign mult     = cfg_ff[`CFG_MULT_MSB:`CFG_MULT_LSB];
  assign pin_profile = {sel_hi_sync_ff, sel_lo_sync_ff};
  assign hi_prof  = profile_ff[1];
  assign act_rate = hi_prof ? p_rate_ff[profile_ff[0]] : 8'h00;
  assign rate_code = act_rate[`RATE_MSB:`RATE_LSB];
  // codes 00h and 01h both behave as bypass, n = 1
  assign n_val    = (rate_code <= `RATE_BYPASS) ? 6'h01 : rate_code;
  assign div_half = {1'b0, n_val[5:1]};
  assign apply_wr = wr_pend_ff & (wr_idx_ff == `IDX_APPLY);
  assign hop_limit = cfg_ff[`CFG_ISINC_BIT] ? `TONE_SW_FULL : `TONE_SW_NOSINC;
  // a burst that opens on a falling sampling edge is captured half a sampling
  // cycle later, so its first sample must come from the hold stage
  assign use_hold = lock_ff ? from_hold_ff : hold_vld_ff;

  // ahb-lite slave, zero wait states; writes land in the data phase
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_ff <= 1'b0;
      wr_idx_ff  <= 8'h00;
      hrdata     <= 32'h00000000;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
    end
    else
    begin
      wr_pend_ff <= bus_take & hwrite;
      wr_idx_ff  <= bus_idx;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
      if (bus_take & ~hwrite)
        hrdata <= rd_mux;
    end
  end

  always @*
  begin
    rd_mux = 32'h00000000;
    case (bus_idx)
      `IDX_P2_FREQ0, `IDX_P2_FREQ1, `IDX_P2_FREQ2, `IDX_P2_FREQ3:
        rd_mux = {24'h000000, p_freq_ff[bus_idx[1:0] - 2'h2]};
      `IDX_P3_FREQ0, `IDX_P3_FREQ1, `IDX_P3_FREQ2, `IDX_P3_FREQ3:
        rd_mux = {24'h000000, p_freq_ff[{1'b1, bus_idx[1:0]}]};
      `IDX_P2_RATE: rd_mux = {24'h000000, p_rate_ff[0]};
      `IDX_P2_GAIN: rd_mux = {24'h000000, p_gain_ff[0]};
      `IDX_P3_RATE: rd_mux = {24'h000000, p_rate_ff[1]};
      `IDX_P3_GAIN: rd_mux = {24'h000000, p_gain_ff[1]};
      `IDX_CONFIG:  rd_mux = cfg_ff;
      `IDX_STATUS:  rd_mux = {22'h0, n_val, tone_busy_ff, 1'b0, profile_ff};
      `IDX_LATENCY: rd_mux = {20'h00000, latency_cycles};
      default:      rd_mux = 32'h00000000;
    endcase
  end

  // register storage; frequency bytes stage here and apply coherently
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (i = 0; i < 8; i = i + 1)
        p_freq_ff[i] <= 8'h00;
      p_rate_ff[0] <= 8'h00;
      p_rate_ff[1] <= 8'h00;
      p_gain_ff[0] <= 8'h00;
      p_gain_ff[1] <= 8'h00;
      cfg_ff       <= `CFG_RESET;
      shadow_ff[0] <= 32'h00000000;
      shadow_ff[1] <= 32'h00000000;
    end
    else
    begin
      if (wr_pend_ff)
      begin
        case (wr_idx_ff)
          `IDX_P2_FREQ0: p_freq_ff[0] <= hwdata[7:0];
          `IDX_P2_FREQ1: p_freq_ff[1] <= hwdata[7:0];
          `IDX_P2_FREQ2: p_freq_ff[2] <= hwdata[7:0];
          `IDX_P2_FREQ3: p_freq_ff[3] <= hwdata[7:0];
          `IDX_P2_RATE:  p_rate_ff[0] <= hwdata[7:0];
          `IDX_P2_GAIN:  p_gain_ff[0] <= hwdata[7:0];
          `IDX_P3_FREQ0: p_freq_ff[4] <= hwdata[7:0];
          `IDX_P3_FREQ1: p_freq_ff[5] <= hwdata[7:0];
          `IDX_P3_FREQ2: p_freq_ff[6] <= hwdata[7:0];
          `IDX_P3_FREQ3: p_freq_ff[7] <= hwdata[7:0];
          `IDX_P3_RATE:  p_rate_ff[1] <= hwdata[7:0];
          `IDX_P3_GAIN:  p_gain_ff[1] <= hwdata[7:0];
          `IDX_CONFIG:
          begin
            // illegal multiplier codes are refused, keeping the last good one
            if ((hwdata[`CFG_MULT_MSB:`CFG_MULT_LSB] == `MULT_BYPASS) ||
                ((hwdata[`CFG_MULT_MSB:`CFG_MULT_LSB] >= `MULT_MIN) &&
                 (hwdata[`CFG_MULT_MSB:`CFG_MULT_LSB] <= `MULT_MAX)))
              cfg_ff <= {23'h0, hwdata[8:0]};
            else
              cfg_ff <= {23'h0, mult, hwdata[3:0]};
          end
          default: ;
        endcase
      end
      if (apply_wr)
      begin
        shadow_ff[0] <= {p_freq_ff[3], p_freq_ff[2], p_freq_ff[1], p_freq_ff[0]};
        shadow_ff[1] <= {p_freq_ff[7], p_freq_ff[6], p_freq_ff[5], p_freq_ff[4]};
      end
    end
  end

  // pin synchronisers, then profile capture
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sel_lo_meta_ff <= 1'b0;
      sel_lo_sync_ff <= 1'b0;
      sel_hi_meta_ff <= 1'b0;
      sel_hi_sync_ff <= 1'b0;
      burst_meta_ff  <= 1'b0;
      burst_sync_ff  <= 1'b0;
      profile_ff     <= 2'h0;
    end
    else
    begin
      sel_lo_meta_ff <= profile_sel_lo;
      sel_lo_sync_ff <= sel_lo_meta_ff;
      sel_hi_meta_ff <= profile_sel_hi;
      sel_hi_sync_ff <= sel_hi_meta_ff;
      burst_meta_ff  <= burst_start;
      burst_sync_ff  <= burst_meta_ff;
      if ((mode == `MODE_TONE) || data_clk_rise)
        profile_ff <= pin_profile;
    end
  end

  // clock divider chain: core/n, /2n, /4n for even n; odd n above 1 acts as n - 1, n = 1 as n = 2
  always @*
  begin
    data_clk_rise = 1'b0;
    if ((n_val == 6'h01) || (div_cnt_ff == div_half - 6'h01))
      data_clk_rise = clk_n_ff & ~parallel_data_clock;
  end

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      div_cnt_ff          <= 6'h00;
      clk_n_ff            <= 1'b0;
      parallel_data_clock <= 1'b0;
      sample_clock        <= 1'b0;
    end
    else
    begin
      // clk_n toggles each n/2 cycles; odd n rounds both phases down, n = 1 toggles every cycle
      if ((n_val == 6'h01) || (div_cnt_ff >= div_half - 6'h01))
      begin
        div_cnt_ff <= 6'h00;
        clk_n_ff   <= ~clk_n_ff;
        if (clk_n_ff)
        begin
          parallel_data_clock <= ~parallel_data_clock;
          if (~parallel_data_clock)
            sample_clock <= ~sample_clock;
        end
      end
      else
        div_cnt_ff <= div_cnt_ff + 6'h01;
    end
  end

  // demux: three data clock stages, then gated to a sampling rising edge
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (i = 0; i < 3; i = i + 1)
        pipe_ff[i] <= 14'h0000;
      pipe_vld_ff <= 3'h0;
      demux_out   <= 14'h0000;
      demux_valid <= 1'b0;
      hold_ff     <= 14'h0000;
      hold_vld_ff <= 1'b0;
      lock_ff     <= 1'b0;
      from_hold_ff <= 1'b0;
    end
    else
    begin
      if (data_clk_rise)
      begin
        pipe_ff[0]  <= sample_in;
        pipe_ff[1]  <= pipe_ff[0];
        pipe_ff[2]  <= pipe_ff[1];
        pipe_vld_ff <= {pipe_vld_ff[1:0], burst_sync_ff};
        hold_ff     <= pipe_ff[2];
        hold_vld_ff <= pipe_vld_ff[2];
        if (~pipe_vld_ff[2])
          lock_ff <= 1'b0;
      end
      demux_valid <= 1'b0;
      // capture only where sample_clock rises: half or full sampling cycle
      if (data_clk_rise & ~sample_clock & pipe_vld_ff[2])
      begin
        demux_out   <= use_hold ? hold_ff : pipe_ff[2];
        demux_valid <= 1'b1;
        // the phase chosen at the first capture stays for the whole burst
        lock_ff      <= 1'b1;
        from_hold_ff <= use_hold;
      end
    end
  end

  // latency sum of engaged stages
  always @*
  begin
    lat_sum = (mode == `MODE_INTERP) ? `LAT_DEMUX_INT : `LAT_DEMUX_MOD;
    lat_sum = lat_sum * {6'h00, n_val};
    if (~act_rate[`RATE_ICIC_BIT])
      lat_sum = lat_sum + `LAT_ICIC * {6'h00, n_val};
    lat_sum = lat_sum + `LAT_FIXED * {6'h00, n_val};
    lat_sum = lat_sum + `LAT_PROG_K * {6'h00, n_val} + `LAT_PROG_C;
    if (mode == `MODE_QMOD)
      lat_sum = lat_sum + `LAT_QMOD;
    if (cfg_ff[`CFG_ISINC_BIT])
      lat_sum = lat_sum + `LAT_ISINC;
    if (cfg_ff[`CFG_SCALE_BIT])
      lat_sum = lat_sum + `LAT_SCALE;
  end

  // profile outputs; single-tone hop completes within the limit
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      active_freq_word   <= 32'h00000000;
      active_gain        <= 8'h00;
      active_spec_invert <= 1'b0;
      active_icic_bypass <= 1'b0;
      latency_cycles     <= 12'h000;
      hop_cnt_ff         <= 5'h00;
      hop_prof_ff        <= 2'h0;
      tone_busy_ff       <= 1'b0;
    end
    else
    begin
      latency_cycles <= lat_sum;
      // tone mode applies after a fixed pipeline, below 30 or 24 cycles
      if (tone_busy_ff && ((mode != `MODE_TONE) ||
          (hop_cnt_ff == (cfg_ff[`CFG_ISINC_BIT] ? `TONE_SW_BASE : `TONE_SW_SHORT))))
      begin
        tone_busy_ff       <= 1'b0;
        active_freq_word   <= hi_prof ? shadow_ff[profile_ff[0]] : 32'h00000000;
        active_gain        <= hi_prof ? p_gain_ff[profile_ff[0]] : 8'h00;
        active_spec_invert <= act_rate[`RATE_INV_BIT];
        active_icic_bypass <= act_rate[`RATE_ICIC_BIT];
      end
      else if (tone_busy_ff && (hop_cnt_ff == hop_limit))
        tone_busy_ff <= 1'b0;
      // placed last so a new hop wins over a clear in the same cycle
      if (profile_ff != hop_prof_ff)
      begin
        hop_prof_ff  <= profile_ff;
        hop_cnt_ff   <= 5'h00;
        tone_busy_ff <= 1'b1;
      end
      else if (tone_busy_ff)
        hop_cnt_ff <= hop_cnt_ff + 5'h01;
    end
  end
endmodule // profile_datapath_latency
`default_nettype wire

// ===== sim/profile_datapath_latency_properties.sv
`default_nettype none
module profile_datapath_latency_checker (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        parallel_data_clock,
  input wire logic        sample_clock,
  input wire logic        demux_valid,
  input wire logic [31:0] active_freq_word
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire  logic take   = hsel && hready && htrans == 2'h2;
  wire  logic fw_wr  = take && hwrite && haddr[9:2] inside {[8'h0E:8'h11], [8'h14:8'h17]};
  ready_high_a: assert property (hreadyout) else $error("hreadyout low");
  okay_resp_a: assert property (!hresp) else $error("hresp not okay");
  rdata_hold_a: assert property (!$past(take && !hwrite) |-> $stable(hrdata))
    else $error("hrdata moved without a read");
  sclk_edge_a: assert property ($changed(sample_clock) |-> $rose(parallel_data_clock))
    else $error("sampling clock moved off a data clock rise");
  sclk_half_a: assert property ($rose(parallel_data_clock) |-> $changed(sample_clock))
    else $error("sampling clock not half the data clock");
  valid_pulse_a: assert property (demux_valid |=> !demux_valid)
    else $error("demux valid longer than one cycle");
  rst_clear_a: assert property ($rose(hresetn) |-> hrdata == 32'h0 && !demux_valid)
    else $error("outputs not cleared by reset");
  word_whole_a: assert property (fw_wr |-> ##2 $stable(active_freq_word) [*3])
    else $error("byte write reached the active word");
  cover property (demux_valid);
  cover property (take && !hwrite);
  cover property ($rose(sample_clock));
endmodule // profile_datapath_latency_checker
bind profile_datapath_latency profile_datapath_latency_checker chk_u (
  .hclk                (hclk),
  .hresetn             (hresetn),
  .hsel                (hsel),
  .haddr               (haddr),
  .htrans              (htrans),
  .hwrite              (hwrite),
  .hready              (hready),
  .hrdata              (hrdata),
  .hreadyout           (hreadyout),
  .hresp               (hresp),
  .parallel_data_clock (parallel_data_clock),
  .sample_clock        (sample_clock),
  .demux_valid         (demux_valid),
  .active_freq_word    (active_freq_word)
);
`default_nettype wire

// ===== sim/sample_source.sv
`default_nettype none
module sample_source (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        parallel_data_clock,
  input  wire logic        src_en,
  output var  logic        burst_start,
  output var  logic [13:0] sample_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        pd_prev_ff;
  logic [13:0] count_ff;
  always @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      pd_prev_ff  <= 1'b0;
      burst_start <= 1'b0;
      sample_in   <= 14'h0000;
      count_ff    <= 14'h1000;
    end
    else
    begin
      pd_prev_ff  <= parallel_data_clock;
      burst_start <= src_en;
      if (!src_en)
      begin
        count_ff  <= 14'h1000;
        sample_in <= ~sample_in; // idle bus must not look like held data
      end
      else if (!burst_start || (parallel_data_clock && !pd_prev_ff))
      begin
        sample_in <= count_ff;
        count_ff  <= count_ff + 14'h0001;
      end
    end
endmodule // sample_source
`default_nettype wire

// ===== sim/profile_datapath_latency_tb_top.sv
`include "profile_latency_defines.vh"
`default_nettype none
module profile_datapath_latency_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, src_en = 0, msel = 0;
  logic        profile_sel_lo = 0, profile_sel_hi = 0;
  logic [31:0] haddr = 0, hwdata = 0, rd;
  logic [31:0] w2 = 32'h12345678, w3 = 32'h0ABCDEF1;
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = 3'h2;
  wire  logic  hready, hreadyout, hresp, burst_start, parallel_data_clock, sample_clock;
  wire  logic  demux_valid, active_spec_invert, active_icic_bypass;
  wire  logic [31:0] hrdata, active_freq_word;
  wire  logic [13:0] sample_in, demux_out;
  wire  logic [7:0]  active_gain;
  wire  logic [11:0] latency_cycles;
  wire  logic  mclk = msel ? sample_clock : parallel_data_clock;
  int          failures = 0, n_compared = 0, cyc = 0, i, t;
  real         lata, latb;
  assign hready = hreadyout;
  profile_datapath_latency dut_u (
    .hclk                (hclk),
    .hresetn             (hresetn),
    .hsel                (hsel),
    .haddr               (haddr),
    .htrans              (htrans),
    .hwrite              (hwrite),
    .hsize               (hsize),
    .hwdata              (hwdata),
    .hready              (hready),
    .hrdata              (hrdata),
    .hreadyout           (hreadyout),
    .hresp               (hresp),
    .profile_sel_lo      (profile_sel_lo),
    .profile_sel_hi      (profile_sel_hi),
    .burst_start         (burst_start),
    .sample_in           (sample_in),
    .parallel_data_clock (parallel_data_clock),
    .sample_clock        (sample_clock),
    .demux_out           (demux_out),
    .demux_valid         (demux_valid),
    .active_freq_word    (active_freq_word),
    .active_gain         (active_gain),
    .active_spec_invert  (active_spec_invert),
    .active_icic_bypass  (active_icic_bypass),
    .latency_cycles      (latency_cycles)
  );
  sample_source src_u (
    .hclk                (hclk),
    .hresetn             (hresetn),
    .parallel_data_clock (parallel_data_clock),
    .src_en              (src_en),
    .burst_start         (burst_start),
    .sample_in           (sample_in)
  );
  initial forever #12.5 hclk = ~hclk;
  task automatic results();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      failures++;
      results();
    end
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'b00};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic hop(input logic [1:0] sel, input logic [31:0] exp);
    {profile_sel_hi, profile_sel_lo} <= sel;
    for (t = 0; t < 300 && active_freq_word !== exp; t++) @(posedge hclk);
    chk("freq word", active_freq_word, exp);
  endtask
  task automatic per(input logic s, input int exp);
    real t0;
    msel = s;
    repeat (2) @(posedge mclk);
    t0 = $realtime;
    @(posedge mclk);
    chk("clock period", int'(($realtime - t0) / 25.0), exp);
  endtask
  // the spread between start phases is measured here, not assumed away
  task automatic burst(input logic rise, output real lat);
    real t0;
    if (rise)
      @(posedge sample_clock);
    else
      @(negedge sample_clock);
    t0 = $realtime;
    src_en <= 1'b1;
    @(posedge demux_valid);
    #1;
    lat = ($realtime - t0) / 25.0;
    chk("first sample", {18'h0, demux_out}, 32'h1000);
    @(posedge hclk);
    src_en <= 1'b0;
    repeat (300) @(posedge hclk);
  endtask
  initial
  begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    xfer(0, `IDX_CONFIG, 0);
    chk("config reset", rd, `CFG_RESET);
    for (i = 0; i < 12; i++)
    begin
      xfer(1, 8'(`IDX_P2_FREQ0 + i), 32'hA0 + i);
      xfer(0, 8'(`IDX_P2_FREQ0 + i), 0);
      chk("profile byte", rd, 32'hA0 + i);
    end
    xfer(0, 8'h1A, 0);
    chk("unmapped", rd, 0);
    for (i = 0; i < 4; i++)
    begin
      xfer(1, 8'(`IDX_P2_FREQ0 + i), w2 >> (8 * i) & 32'hFF);
      xfer(1, 8'(`IDX_P3_FREQ0 + i), w3 >> (8 * i) & 32'hFF);
    end
    xfer(1, `IDX_P2_RATE, 32'h54);
    xfer(1, `IDX_P2_GAIN, 32'h80);
    xfer(1, `IDX_P3_RATE, 32'h81);
    xfer(1, `IDX_P3_GAIN, 32'hFF);
    xfer(1, `IDX_APPLY, 0);
    xfer(1, `IDX_CONFIG, 32'h4A);
    hop(2'b10, w2);
    chk("p2 fields", {10'h0, active_spec_invert, active_icic_bypass, active_gain,
      latency_cycles}, {10'h0, 2'b10, 8'h80, 12'h7A3});
    xfer(0, `IDX_STATUS, 0);
    chk("status n", rd & 32'h3F3, 32'h142);
    hop(2'b11, w3);
    chk("p3 fields", {10'h0, active_spec_invert, active_icic_bypass, active_gain,
      latency_cycles}, {10'h0, 2'b01, 8'hFF, 12'h064});
    xfer(0, `IDX_STATUS, 0);
    chk("status bypass", rd & 32'h3F3, 32'h013);
    xfer(1, `IDX_CONFIG, 32'h44);
    hop(2'b10, w2);
    chk("qmod latency", {20'h0, latency_cycles}, 32'h75B);
    per(0, 40);
    per(1, 80);
    burst(1, lata);
    burst(0, latb);
    chk("phase delta", int'(latb - lata), 40);
    xfer(1, `IDX_CONFIG, 32'h4D);
    hop(2'b11, w3);
    chk("hop full", {31'h0, t < 30}, 1);
    xfer(1, `IDX_CONFIG, 32'h49);
    hop(2'b10, w2);
    chk("hop no sinc", {31'h0, t < 24}, 1);
    xfer(1, `IDX_CONFIG, 32'h25);
    xfer(0, `IDX_CONFIG, 0);
    chk("multiplier kept", rd & 32'h1F0, 32'h40);
    results();
  end
endmodule // profile_datapath_latency_tb_top
`default_nettype wire
